// file: rtl/pmcr_pkg.sv
// How it works
// - port 2 latch holds eight cpu-writable bits, one per pin
// - port 3 latch holds writable bits 7 and 5..0; bit 6 has no pin
// - port 1 mode reg b reads all zeros after reset
// - port 3 latch resets to ones in bits 7 and 5..0
// - both port 3 mode registers reset to zero, default mode
// - mode pair (a,b): 00 quasi, 01 push-pull, 10 input, 11 open-drain
// - quasi pin latch rising 0 to 1 enables strong pull-up two clocks
package pmcr_pkg;
  localparam logic [7:0] ADDR_P1_SEL_B   = 8'h92;
  localparam logic [7:0] ADDR_P2_SEL_A   = 8'h95;
  localparam logic [7:0] ADDR_P2_SEL_B   = 8'h96;
  localparam logic [7:0] ADDR_P2_LATCH   = 8'hA0;
  localparam logic [7:0] ADDR_P3_LATCH   = 8'hB0;
  localparam logic [7:0] ADDR_P3_SEL_A   = 8'hB1;
  localparam logic [7:0] ADDR_P3_SEL_B   = 8'hB2;
  localparam logic [7:0] RST_P1_SEL_B    = 8'h00;
  localparam logic [7:0] RST_SEL         = 8'h00;
  localparam logic [7:0] RST_P2_LATCH    = 8'hFF;
  localparam logic [7:0] RST_P3_LATCH    = 8'hBF;
  localparam logic [7:0] P3_IMPL_MASK    = 8'hBF;
  localparam int         P3_EMPTY_BIT    = 6;
  localparam logic [1:0] STRONG_PU_CYC   = 2'h2;

  typedef enum logic [1:0] {
    PMCR_QUASI = 2'b00,
    PMCR_PUSH  = 2'b01,
    PMCR_INPUT = 2'b10,
    PMCR_OPEN  = 2'b11
  } pmcr_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmcr_sfr_req_s;

  typedef struct packed {
    logic [7:0] drive_high;
    logic [7:0] drive_low;
    logic [7:0] strong_pu;
    logic [7:0] weak_pu;
  } pmcr_pin_ctl_s;
endpackage : pmcr_pkg

// file: rtl/pmcr_pin_ctl.sv
`timescale 1ns/100ps
module pmcr_pin_ctl #(
  parameter int WIDTH = 8
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic [WIDTH-1:0]     latch,
  input  wire logic [WIDTH-1:0]     sel_a,
  input  wire logic [WIDTH-1:0]     sel_b,
  output logic      [WIDTH-1:0]     drive_high,
  output logic      [WIDTH-1:0]     drive_low,
  output logic      [WIDTH-1:0]     strong_pu,
  output logic      [WIDTH-1:0]     weak_pu
);
  logic [WIDTH-1:0] latch_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      latch_q <= '1;
    end else begin
      latch_q <= latch;
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    logic [1:0]              pu_cnt;
    logic                    hi_q;
    logic                    lo_q;
    logic                    sp_q;
    logic                    wp_q;
    pmcr_pkg::pmcr_mode_e    mode;
    assign mode = pmcr_pkg::pmcr_mode_e'({sel_a[i], sel_b[i]});

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        pu_cnt <= 2'h0;
      end else if (mode == pmcr_pkg::PMCR_QUASI
                   && latch[i] && !latch_q[i]) begin
        pu_cnt <= pmcr_pkg::STRONG_PU_CYC;
      end else if (pu_cnt != 2'h0) begin
        pu_cnt <= pu_cnt - 2'h1;
      end
    end

    // registered so drivers follow register writes one clock later;
    // each pin keeps its own flops so no output vector has many writers
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        hi_q <= 1'b0;
        lo_q <= 1'b0;
        sp_q <= 1'b0;
        wp_q <= 1'b0;
      end else begin
        hi_q <= (mode == pmcr_pkg::PMCR_PUSH) && latch[i];
        lo_q <= (mode != pmcr_pkg::PMCR_INPUT) && !latch[i];
        wp_q <= (mode == pmcr_pkg::PMCR_QUASI) && latch[i];
        sp_q <= (mode == pmcr_pkg::PMCR_QUASI) && latch[i]
                && ((latch[i] && !latch_q[i])
                    || (pu_cnt > 2'h1));
      end
    end

    assign drive_high[i] = hi_q;
    assign drive_low[i]  = lo_q;
    assign strong_pu[i]  = sp_q;
    assign weak_pu[i]    = wp_q;
  end
endmodule : pmcr_pin_ctl

// file: rtl/pmcr_port_regs.sv
`timescale 1ns/100ps
module pmcr_port_regs (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire pmcr_pkg::pmcr_sfr_req_s sfr_req,
  output logic [7:0]                  sfr_rdata,
  output logic                        sfr_hit,
  input  wire logic [7:0]             port1_drive_select_a,
  output logic [7:0]                  port1_drive_select_b,
  input  wire logic [7:0]             port1_output_latch,
  output logic [7:0]                  port2_output_latch,
  output logic [7:0]                  port3_output_latch,
  output pmcr_pkg::pmcr_pin_ctl_s     port1_pins,
  output pmcr_pkg::pmcr_pin_ctl_s     port2_pins,
  output pmcr_pkg::pmcr_pin_ctl_s     port3_pins
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] port2_drive_select_a;
  logic [7:0] port2_drive_select_b;
  logic [7:0] port3_drive_select_a;
  logic [7:0] port3_drive_select_b;
  logic       wr;
  logic [7:0] wd;

  assign wr = sfr_req.wr;
  assign wd = sfr_req.wdata;

  ////////////////////////////////////////////////////////////////////////
  // one strobe per register; an unmapped address raises none, so such
  // a write is dropped and no register moves; the first match wins, which
  // would only matter if two offsets were ever set equal
  logic wr_p1_sel_b;
  logic wr_p2_sel_a;
  logic wr_p2_sel_b;
  logic wr_p2_latch;
  logic wr_p3_latch;
  logic wr_p3_sel_a;
  logic wr_p3_sel_b;

  always_comb begin
    wr_p1_sel_b = 1'b0;
    wr_p2_sel_a = 1'b0;
    wr_p2_sel_b = 1'b0;
    wr_p2_latch = 1'b0;
    wr_p3_latch = 1'b0;
    wr_p3_sel_a = 1'b0;
    wr_p3_sel_b = 1'b0;
    if (wr) begin
      if (sfr_req.addr == pmcr_pkg::ADDR_P1_SEL_B) begin
        wr_p1_sel_b = 1'b1;
      end else if (sfr_req.addr == pmcr_pkg::ADDR_P2_SEL_A) begin
        wr_p2_sel_a = 1'b1;
      end else if (sfr_req.addr == pmcr_pkg::ADDR_P2_SEL_B) begin
        wr_p2_sel_b = 1'b1;
      end else if (sfr_req.addr == pmcr_pkg::ADDR_P2_LATCH) begin
        wr_p2_latch = 1'b1;
      end else if (sfr_req.addr == pmcr_pkg::ADDR_P3_LATCH) begin
        wr_p3_latch = 1'b1;
      end else if (sfr_req.addr == pmcr_pkg::ADDR_P3_SEL_A) begin
        wr_p3_sel_a = 1'b1;
      end else if (sfr_req.addr == pmcr_pkg::ADDR_P3_SEL_B) begin
        wr_p3_sel_b = 1'b1;
      end
    end
  end

  // bit 6 of port 3 has no pad, so none of its registers stores it; the
  // one or zero that software puts there is dropped here
  logic [7:0] next_port3_output_latch;
  logic [7:0] next_port3_drive_select_a;
  logic [7:0] next_port3_drive_select_b;

  assign next_port3_output_latch   = wd & pmcr_pkg::P3_IMPL_MASK;
  assign next_port3_drive_select_a = wd & pmcr_pkg::P3_IMPL_MASK;
  assign next_port3_drive_select_b = wd & pmcr_pkg::P3_IMPL_MASK;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port1_drive_select_b <= pmcr_pkg::RST_P1_SEL_B;
    end else if (wr_p1_sel_b) begin
      port1_drive_select_b <= wd;
    end
  end

  // port 2 mode reset value unprinted; zero keeps pins quasi
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port2_drive_select_a <= pmcr_pkg::RST_SEL;
    end else if (wr_p2_sel_a) begin
      port2_drive_select_a <= wd;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port2_drive_select_b <= pmcr_pkg::RST_SEL;
    end else if (wr_p2_sel_b) begin
      port2_drive_select_b <= wd;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port2_output_latch <= pmcr_pkg::RST_P2_LATCH;
    end else if (wr_p2_latch) begin
      port2_output_latch <= wd;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port3_output_latch <= pmcr_pkg::RST_P3_LATCH;
    end else if (wr_p3_latch) begin
      port3_output_latch <= next_port3_output_latch;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port3_drive_select_a <= pmcr_pkg::RST_SEL;
    end else if (wr_p3_sel_a) begin
      port3_drive_select_a <= next_port3_drive_select_a;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port3_drive_select_b <= pmcr_pkg::RST_SEL;
    end else if (wr_p3_sel_b) begin
      port3_drive_select_b <= next_port3_drive_select_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reads have no side effect, so the mux follows the address alone;
  // the read marker of the request is not needed here
  always_comb begin
    sfr_hit   = 1'b1;
    sfr_rdata = 8'h00;
    if (sfr_req.addr == pmcr_pkg::ADDR_P1_SEL_B) begin
      sfr_rdata = port1_drive_select_b;
    end else if (sfr_req.addr == pmcr_pkg::ADDR_P2_SEL_A) begin
      sfr_rdata = port2_drive_select_a;
    end else if (sfr_req.addr == pmcr_pkg::ADDR_P2_SEL_B) begin
      sfr_rdata = port2_drive_select_b;
    end else if (sfr_req.addr == pmcr_pkg::ADDR_P2_LATCH) begin
      sfr_rdata = port2_output_latch;
    end else if (sfr_req.addr == pmcr_pkg::ADDR_P3_LATCH) begin
      sfr_rdata = port3_output_latch;
    end else if (sfr_req.addr == pmcr_pkg::ADDR_P3_SEL_A) begin
      sfr_rdata = port3_drive_select_a;
    end else if (sfr_req.addr == pmcr_pkg::ADDR_P3_SEL_B) begin
      sfr_rdata = port3_drive_select_b;
    end else begin
      sfr_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port 3 bit 6 has no pad: its latch input is held at one so it never
  // fires a strong pull-up, and its controls are tied low further down
  logic [7:0] p3_hi;
  logic [7:0] p3_lo;
  logic [7:0] p3_sp;
  logic [7:0] p3_wp;
  logic [7:0] p3_latch_in;
  assign p3_latch_in = port3_output_latch | ~pmcr_pkg::P3_IMPL_MASK;

  // one pin decoder per port; port 1's mode a register and latch live
  // outside this block and come in as plain inputs
  pmcr_pin_ctl #(.WIDTH(8)) u_p1 (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .latch      (port1_output_latch),
    .sel_a      (port1_drive_select_a),
    .sel_b      (port1_drive_select_b),
    .drive_high (port1_pins.drive_high),
    .drive_low  (port1_pins.drive_low),
    .strong_pu  (port1_pins.strong_pu),
    .weak_pu    (port1_pins.weak_pu)
  );

  pmcr_pin_ctl #(.WIDTH(8)) u_p2 (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .latch      (port2_output_latch),
    .sel_a      (port2_drive_select_a),
    .sel_b      (port2_drive_select_b),
    .drive_high (port2_pins.drive_high),
    .drive_low  (port2_pins.drive_low),
    .strong_pu  (port2_pins.strong_pu),
    .weak_pu    (port2_pins.weak_pu)
  );

  pmcr_pin_ctl #(.WIDTH(8)) u_p3 (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .latch      (p3_latch_in),
    .sel_a      (port3_drive_select_a),
    .sel_b      (port3_drive_select_b),
    .drive_high (p3_hi),
    .drive_low  (p3_lo),
    .strong_pu  (p3_sp),
    .weak_pu    (p3_wp)
  );

  for (genvar j = 0; j < 8; j++) begin : g_p3_pad
    if (j == pmcr_pkg::P3_EMPTY_BIT) begin : g_none
      assign port3_pins.drive_high[j] = 1'b0;
      assign port3_pins.drive_low[j]  = 1'b0;
      assign port3_pins.strong_pu[j]  = 1'b0;
      assign port3_pins.weak_pu[j]    = 1'b0;
    end else begin : g_pad
      assign port3_pins.drive_high[j] = p3_hi[j];
      assign port3_pins.drive_low[j]  = p3_lo[j];
      assign port3_pins.strong_pu[j]  = p3_sp[j];
      assign port3_pins.weak_pu[j]    = p3_wp[j];
    end
  end
endmodule : pmcr_port_regs

// file: tb/pmcr_port_regs_monitor.sv
`timescale 1ns/100ps
module pmcr_port_regs_monitor (
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire pmcr_pkg::pmcr_sfr_req_s sfr_req,
  input wire logic [7:0]              sfr_rdata,
  input wire logic                    sfr_hit,
  input wire logic [7:0]              port1_drive_select_a,
  input wire logic [7:0]              port1_drive_select_b,
  input wire logic [7:0]              port1_output_latch,
  input wire logic [7:0]              port2_output_latch,
  input wire logic [7:0]              port3_output_latch,
  input wire pmcr_pkg::pmcr_pin_ctl_s port1_pins,
  input wire pmcr_pkg::pmcr_pin_ctl_s port2_pins,
  input wire pmcr_pkg::pmcr_pin_ctl_s port3_pins
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic a0 = port1_drive_select_a[0];
  wire logic b0 = port1_drive_select_b[0];
  wire logic l0 = port1_output_latch[0];
  wire logic w2 = sfr_req.wr && sfr_req.addr == pmcr_pkg::ADDR_P2_LATCH;
  wire logic w3 = sfr_req.wr && sfr_req.addr == pmcr_pkg::ADDR_P3_LATCH;
  wire logic w1 = sfr_req.wr && sfr_req.addr == pmcr_pkg::ADDR_P1_SEL_B;
  ////////////////////////////////////////////////////////////////////////////
  AST_P2_WR: assert property (
    w2 |=> port2_output_latch == $past(sfr_req.wdata)) else $error("p2 wr");
  AST_P3_WR: assert property (
    w3 |=> port3_output_latch == ($past(sfr_req.wdata) & 8'hBF))
    else $error("p3 wr");
  AST_P1B_WR: assert property (
    w1 |=> port1_drive_select_b == $past(sfr_req.wdata)) else $error("p1 wr");
  AST_UNMAPPED: assert property (
    !sfr_hit |-> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  AST_READBACK: assert property (
    sfr_req.addr == pmcr_pkg::ADDR_P2_LATCH |->
      sfr_hit && sfr_rdata == port2_output_latch) else $error("readback");
  AST_STRONG: assert property (
    $rose(port2_pins.strong_pu[0]) |-> !$past(port2_output_latch[0], 2)
      ##1 port2_pins.strong_pu[0] ##1 !port2_pins.strong_pu[0])
    else $error("strong pull-up length");
  AST_INPUT: assert property (
    (a0 && !b0)[*3] |-> port1_pins.drive_high[0] == 1'b0 &&
      port1_pins.drive_low[0] == 1'b0 && port1_pins.weak_pu[0] == 1'b0)
    else $error("input mode drives");
  AST_PUSH: assert property (
    (!a0 && b0 && $stable(l0))[*3] |-> port1_pins.drive_high[0] == l0 &&
      port1_pins.drive_low[0] == !l0) else $error("push-pull levels");
  AST_OPEN: assert property (
    (a0 && b0 && $stable(l0))[*3] |-> port1_pins.drive_low[0] == !l0 &&
      !port1_pins.drive_high[0] && !port1_pins.weak_pu[0])
    else $error("open-drain levels");
  AST_P3_NOPIN: assert property (
    !port3_pins.drive_low[6] && !port3_pins.weak_pu[6]) else $error("p3 b6");
endmodule : pmcr_port_regs_monitor
bind pmcr_port_regs pmcr_port_regs_monitor i_pmcr_port_regs_monitor (
  .clk_sys(clk_sys), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .sfr_hit(sfr_hit), .port1_drive_select_a(port1_drive_select_a),
  .port1_drive_select_b(port1_drive_select_b),
  .port1_output_latch(port1_output_latch),
  .port2_output_latch(port2_output_latch),
  .port3_output_latch(port3_output_latch), .port1_pins(port1_pins),
  .port2_pins(port2_pins), .port3_pins(port3_pins));

// file: tb/pmcr_port_regs_test.sv
`timescale 1ns/100ps
module pmcr_port_regs_test;
  logic                    clk_sys;
  logic                    rst;
  pmcr_pkg::pmcr_sfr_req_s sfr_req;
  logic [7:0]              rdata, p1a, p1b, p1l, p2l, p3l;
  logic                    hit;
  pmcr_pkg::pmcr_pin_ctl_s p1p, p2p, p3p;
  int                      num_errors, n_checks;
  logic [7:0] adr[7] = '{8'h92, 8'h95, 8'h96, 8'hA0, 8'hB0, 8'hB1, 8'hB2};
  logic [7:0] rsv[7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hBF, 8'h00, 8'h00};
  pmcr_port_regs i_pmcr_port_regs (.clk_sys(clk_sys), .rst(rst),
    .sfr_req(sfr_req), .sfr_rdata(rdata), .sfr_hit(hit),
    .port1_drive_select_a(p1a), .port1_drive_select_b(p1b),
    .port1_output_latch(p1l), .port2_output_latch(p2l),
    .port3_output_latch(p3l), .port1_pins(p1p), .port2_pins(p2p),
    .port3_pins(p3p));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    #1;
    sfr_req.wr = 1'b0;
  endtask : wr
  // read data is combinational, so it is judged 6 ns into the 20 ns cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk_sys);
    #1;
    sfr_req.addr = a;
    sfr_req.rd = 1'b1;
    #5;
    check(rdata, e);
    check({7'h00, hit}, {7'h00, h});
    @(posedge clk_sys);
    #1;
    sfr_req.rd = 1'b0;
  endtask : rd
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 7; i++) rd(adr[i], rsv[i], 1'b1);
    rd(8'h93, 8'h00, 1'b0);
    check(p3p.weak_pu, pmcr_pkg::P3_IMPL_MASK);
    check(p3p.drive_low, 8'h00);
  endtask : t_reset
  task automatic t_strong();
    wr(8'hA0, 8'h00);
    wr(8'hA0, 8'hFF);
    check(p2p.strong_pu, 8'h00);
    @(posedge clk_sys);
    #1;
    check(p2p.strong_pu, 8'hFF);
    @(posedge clk_sys);
    #1;
    check(p2p.strong_pu, 8'hFF);
    @(posedge clk_sys);
    #1;
    check(p2p.strong_pu, 8'h00);
    check(p2p.weak_pu, 8'hFF);
  endtask : t_strong
  // port 3 latch gets its empty bit set, mode regs get it cleared
  task automatic t_regs();
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      d = (i == 4) ? 8'hE5 : 8'hA5 ^ 8'(i);
      wr(adr[i], d);
      rd(adr[i], (i >= 4) ? (d & 8'hBF) : d, 1'b1);
    end
    check(p1b, 8'hA5);
    check(p2l, 8'hA6);
    check(p3l, 8'hA5);
    check(p3p.drive_high, 8'h01);
    check(p3p.drive_low, 8'h1A);
    check(p3p.weak_pu, 8'h04);
    check(p3p.strong_pu, 8'h00);
    wr(8'h93, 8'hFF);
    rd(8'h93, 8'h00, 1'b0);
  endtask : t_regs
  task automatic t_modes();
    logic [1:0] m;
    for (int k = 0; k < 8; k++) begin
      m = k[2:1];
      p1a = {7'h00, m[1]};
      wr(8'h92, {7'h00, m[0]});
      p1l = {7'h7F, k[0]};
      // long wait lets a strong pull-up pulse die out first
      repeat (5) @(posedge clk_sys);
      #1;
      check({4'h0, p1p.drive_high[0], p1p.drive_low[0], p1p.strong_pu[0],
        p1p.weak_pu[0]}, {4'h0, m == 2'h1 && k[0], m != 2'h2 && !k[0],
        1'b0, m == 2'h0 && k[0]});
    end
  endtask : t_modes
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
  initial begin
    sfr_req = '0;
    p1a = 8'h00;
    p1l = 8'hFF;
    rst = 1'b1;
    num_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset();
    t_strong();
    t_regs();
    t_modes();
    finish_test();
  end
endmodule : pmcr_port_regs_test
